// >>> src/sfc_pkg.sv
`default_nettype none
package sfc_pkg;
  // Frame field values and widths.
  localparam logic [7:0] ATTN_BYTE = 8'h07;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam int HDR_CMD_BYTES = 3;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;
  // Receive states, one-hot.
  typedef enum logic [5:0] {
    SFC_IDLE = 6'h01,
    SFC_ADDR = 6'h02,
    SFC_CMD = 6'h04,
    SFC_LEN = 6'h08,
    SFC_HCHK = 6'h10,
    SFC_DATA = 6'h20
  } sfc_state_t;
endpackage
`default_nettype wire

// >>> src/sfc_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module sfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Handshakes; full and empty follow the occupancy count.
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  // Storage is written without reset since count guards every read.
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // Pointers wrap naturally because the depth is a power of two.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + AW'(1);
      if (pop)
        rd_ptr <= rd_ptr + AW'(1);
      if (push && !pop)
        count <= count + (AW+1)'(1);
      else if (pop && !push)
        count <= count - (AW+1)'(1);
    end
  end
endmodule
`default_nettype wire

// >>> src/sfc_checker.sv
// Contract
// - Data checksum sums all data bytes, wrapping modulo 256.
// - Data checksum byte is the inverted 8-bit data byte sum.
// - Header checksum is inverted sum of attention, address, three commands, length.
// - Data bytes and data checksum never enter the header checksum.
// - Length byte gives the number of data bytes.
// - Data bytes in order, followed by exactly one data checksum byte.
// - Attention byte 0x07 opens every frame and marks a new command.
`timescale 1ns/100ps
`default_nettype none
module sfc_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Received byte stream.
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [7:0] rx_byte,
  // Frame verdict.
  output logic frame_done,
  output logic header_mismatch,
  output logic data_mismatch,
  output logic [7:0] header_checksum,
  output logic [7:0] data_checksum,
  // Accepted data bytes.
  output logic data_valid,
  input wire logic data_ready,
  output logic [7:0] data_byte
);
  sfc_pkg::sfc_state_t state;
  logic [7:0] hsum;
  logic [7:0] dsum;
  logic [7:0] len_left;
  logic [1:0] cmd_cnt;
  logic take;
  logic f_in_ready;
  logic f_out_valid;
  logic f_out_ready;
  logic [7:0] f_out_data;
  logic data_push;
  logic last_data;

  // Modulo-256 accumulation; the carry out of bit 7 is the wrap past 255.
  function automatic logic [7:0] add8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0];
  endfunction

  // A byte is only taken when the data FIFO can absorb a possible data byte.
  assign take = rx_valid && rx_ready;
  assign data_push = take && (state == sfc_pkg::SFC_DATA) && (len_left != 8'h00);
  assign last_data = (state == sfc_pkg::SFC_DATA) && (len_left == 8'h00);

  // The FIFO pops exactly when the output register loads, so no byte is ever doubled.
  assign f_out_ready = !data_valid || data_ready;

  // Ready drops for one cycle after each data byte: a registered ready cannot see the FIFO fill in
  // the same cycle, so the data rate is halved in exchange for never overrunning the buffer.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rx_ready <= 1'b0;
    else
      rx_ready <= f_in_ready && !data_push;
  end

  // Every data byte that is taken must find room in the FIFO.
  property p_no_overrun;
    @(posedge clk) disable iff (!reset_n)
      data_push |-> f_in_ready;
  endproperty
  a_no_overrun: assert property (p_no_overrun)
    else $error("Data byte taken while the FIFO was full.");

  // Frame sequencer; bytes before an attention byte are discarded.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= sfc_pkg::SFC_IDLE;
      cmd_cnt <= 2'h0;
      len_left <= 8'h00;
    end
    else if (take)
    begin
      unique case (state)
        sfc_pkg::SFC_IDLE:
          if (rx_byte == sfc_pkg::ATTN_BYTE)
            state <= sfc_pkg::SFC_ADDR;
        sfc_pkg::SFC_ADDR:
        begin
          state <= sfc_pkg::SFC_CMD;
          cmd_cnt <= 2'h0;
        end
        sfc_pkg::SFC_CMD:
        begin
          cmd_cnt <= cmd_cnt + 2'h1;
          if (cmd_cnt == 2'(sfc_pkg::HDR_CMD_BYTES - 1))
            state <= sfc_pkg::SFC_LEN;
        end
        sfc_pkg::SFC_LEN:
        begin
          len_left <= rx_byte;
          state <= sfc_pkg::SFC_HCHK;
        end
        sfc_pkg::SFC_HCHK:
          state <= sfc_pkg::SFC_DATA;
        sfc_pkg::SFC_DATA:
          if (len_left == 8'h00)
            state <= sfc_pkg::SFC_IDLE;
          else
            len_left <= len_left - 8'h01;
      endcase
    end
  end

  // Only the attention byte may move the sequencer out of idle.
  property p_attn_start;
    @(posedge clk) disable iff (!reset_n)
      take && state == sfc_pkg::SFC_IDLE |=>
        (state == sfc_pkg::SFC_ADDR) == ($past(rx_byte) == sfc_pkg::ATTN_BYTE);
  endproperty
  a_attn_start: assert property (p_attn_start)
    else $error("Idle exit does not follow the attention byte.");

  // The length byte loads the count of data bytes still to come.
  property p_len_load;
    @(posedge clk) disable iff (!reset_n)
      take && state == sfc_pkg::SFC_LEN |=> len_left == $past(rx_byte) && state == sfc_pkg::SFC_HCHK;
  endproperty
  a_len_load: assert property (p_len_load)
    else $error("Length byte did not load the data count.");

  // Header sum covers attention to length only; data bytes never touch it.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      hsum <= 8'h00;
    else if (take)
    begin
      if (state == sfc_pkg::SFC_IDLE)
        hsum <= rx_byte;
      else if (state == sfc_pkg::SFC_ADDR || state == sfc_pkg::SFC_CMD || state == sfc_pkg::SFC_LEN)
        hsum <= add8(hsum, rx_byte);
    end
  end

  // Checksum and data bytes must leave the header sum untouched.
  property p_hsum_hold;
    @(posedge clk) disable iff (!reset_n)
      take && (state == sfc_pkg::SFC_HCHK || state == sfc_pkg::SFC_DATA) |=> $stable(hsum);
  endproperty
  a_hsum_hold: assert property (p_hsum_hold)
    else $error("Header sum moved outside the header.");

  // Data sum restarts at each header checksum byte.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      dsum <= 8'h00;
    else if (take)
    begin
      if (state == sfc_pkg::SFC_HCHK)
        dsum <= 8'h00;
      else if (data_push)
        dsum <= add8(dsum, rx_byte);
    end
  end

  // Each data byte adds into the data sum with the carry past 255 dropped.
  property p_dsum_add;
    @(posedge clk) disable iff (!reset_n)
      data_push |=> dsum == 8'($past(dsum) + $past(rx_byte));
  endproperty
  a_dsum_add: assert property (p_dsum_add)
    else $error("Data sum did not wrap modulo 256.");

  // Verdicts are registered; header results stand until the next header checksum byte, data results until the next frame ends.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      header_mismatch <= 1'b0;
      data_mismatch <= 1'b0;
      header_checksum <= 8'h00;
      data_checksum <= 8'h00;
      frame_done <= 1'b0;
    end
    else
    begin
      frame_done <= take && last_data;
      if (take && state == sfc_pkg::SFC_HCHK)
      begin
        header_checksum <= ~hsum;
        header_mismatch <= (rx_byte != ~hsum);
      end
      if (take && last_data)
      begin
        data_checksum <= ~dsum;
        data_mismatch <= (rx_byte != ~dsum);
      end
    end
  end

  // Data bytes are buffered so a slow consumer throttles the stream.
  sfc_fifo #(
    .WIDTH(sfc_pkg::FIFO_WIDTH),
    .DEPTH(sfc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(data_push),
    .in_ready(f_in_ready),
    .in_data(rx_byte),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  // Output register stage so outputs come from flip-flops.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      data_valid <= 1'b0;
      data_byte <= 8'h00;
    end
    else if (!data_valid || data_ready)
    begin
      data_valid <= f_out_valid;
      data_byte <= f_out_data;
    end
  end

  // A stalled output byte must stand unchanged until the consumer takes it.
  property p_out_hold;
    @(posedge clk) disable iff (!reset_n)
      data_valid && !data_ready |=> data_valid && $stable(data_byte);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("Data byte changed before it was taken.");

  // The header verdict follows the header checksum byte by one cycle.
  property p_hdr_chk;
    @(posedge clk) disable iff (!reset_n)
      take && state == sfc_pkg::SFC_HCHK |=> header_checksum == ~$past(hsum)
        && header_mismatch == ($past(rx_byte) != ~$past(hsum));
  endproperty
  a_hdr_chk: assert property (p_hdr_chk)
    else $error("Header checksum verdict is wrong.");

  // The data verdict and the frame end follow the data checksum byte by one cycle.
  property p_data_chk;
    @(posedge clk) disable iff (!reset_n)
      take && last_data |=> frame_done && data_checksum == ~$past(dsum)
        && data_mismatch == ($past(rx_byte) != ~$past(dsum));
  endproperty
  a_data_chk: assert property (p_data_chk)
    else $error("Data checksum verdict is wrong.");

  // Scenarios worth seeing: both kinds of mismatch, a frame without data and a full buffer.
  c_hdr_bad: cover property (@(posedge clk) disable iff (!reset_n)
    take && state == sfc_pkg::SFC_HCHK && rx_byte != ~hsum);
  c_data_bad: cover property (@(posedge clk) disable iff (!reset_n)
    take && last_data && rx_byte != ~dsum);
  c_empty_frame: cover property (@(posedge clk) disable iff (!reset_n)
    take && state == sfc_pkg::SFC_LEN && rx_byte == 8'h00);
  c_fifo_full: cover property (@(posedge clk) disable iff (!reset_n) !f_in_ready);
endmodule
`default_nettype wire

// >>> verif/sfc_host.sv
`timescale 1ns/100ps
`default_nettype none
module sfc_host (
  // Clock and pacing.
  input wire logic clk,
  input wire logic stall,
  // Byte stream to the device.
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_byte
);
  logic [7:0] q[$];
  initial
  begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
  end
  // An idle line inverts its byte every cycle, so stale data never stands still on the line.
  always @(posedge clk)
  begin
    if (!rx_valid || rx_ready)
    begin
      if (q.size() != 0 && !stall)
      begin
        rx_valid <= 1'b1;
        rx_byte <= q.pop_front();
      end
      else
      begin
        rx_valid <= 1'b0;
        rx_byte <= ~rx_byte;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/serial_frame_checksum_bench.sv
`timescale 1ns/100ps
`default_nettype none
module serial_frame_checksum_bench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic stall = 1'b0;
  logic hold = 1'b0;
  logic data_ready = 1'b0;
  logic rx_valid, rx_ready, frame_done, header_mismatch, data_mismatch, data_valid;
  logic [7:0] rx_byte, header_checksum, data_checksum, data_byte;
  logic [7:0] lfsr = 8'h2A;
  logic [7:0] exp_d[$];
  logic [17:0] exp_f[$];
  logic [17:0] f;
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  sfc_host sfc_host_i (.clk, .stall, .rx_valid, .rx_ready, .rx_byte);
  sfc_checker sfc_checker_i (.clk, .reset_n, .rx_valid, .rx_ready, .rx_byte, .frame_done, .header_mismatch,
    .data_mismatch, .header_checksum, .data_checksum, .data_valid, .data_ready, .data_byte);
  // The clock toggles every half period.
  always #2 clk = ~clk;
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Builds one frame with integer sums; a junk byte ahead of it must be skipped.
  task automatic frame(input int n, input logic [7:0] bh, input logic [7:0] bd);
    int hs;
    int ds;
    logic [7:0] b;
    hs = 7 + n;
    ds = 0;
    sfc_host_i.q.push_back(8'h55);
    sfc_host_i.q.push_back(sfc_pkg::ATTN_BYTE);
    repeat (4)
    begin
      b = rnd();
      hs += b;
      sfc_host_i.q.push_back(b);
    end
    sfc_host_i.q.push_back(n[7:0]);
    sfc_host_i.q.push_back(8'(~hs) ^ bh);
    repeat (n)
    begin
      b = rnd();
      ds += b;
      exp_d.push_back(b);
      sfc_host_i.q.push_back(b);
    end
    sfc_host_i.q.push_back(8'(~ds) ^ bd);
    exp_f.push_back({bd != 8'h00, bh != 8'h00, 8'(~ds), 8'(~hs)});
  endtask
  // Results are compared where they show; pacing on both sides is random.
  always @(posedge clk)
  begin
    cyc++;
    if (data_valid && data_ready)
      check(data_byte, exp_d.pop_front());
    if (frame_done)
    begin
      f = exp_f.pop_front();
      check(header_checksum, f[7:0]);
      check(data_checksum, f[15:8]);
      check({7'h00, header_mismatch}, {7'h00, f[16]});
      check({7'h00, data_mismatch}, {7'h00, f[17]});
    end
    stall <= rnd() < 8'h30;
    data_ready <= !hold && rnd() > 8'h50;
    if (cyc == 20000)
    begin
      errors++;
      finish_test();
    end
  end
  // Fill the buffer until refused, then run frames back to back with wrap and bad checksums.
  initial
  begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    hold <= 1'b1;
    frame(12, 8'h00, 8'h00);
    repeat (60) @(negedge clk);
    check({7'h00, rx_ready}, 8'h00);
    hold <= 1'b0;
    for (int i = 0; i < 30; i++)
      frame(i % 13, (i % 13 == 0) ? 8'h01 : 8'h00, (i % 4 == 3) ? 8'h80 : 8'h00);
    while (exp_f.size() != 0 || exp_d.size() != 0)
      @(posedge clk);
    repeat (4) @(posedge clk);
    finish_test();
  end
endmodule
`default_nettype wire
